// *** preset_seq_pkg.sv ***
package preset_seq_pkg;
   // ----------------------------------------------------------------
   // register word offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;      // enable, sources, feature switches
   localparam logic [7:0] TOTAL_OFS = 8'h04;     // presets in use
   localparam logic [7:0] REPEAT_OFS = 8'h08;    // events per preset
   localparam logic [7:0] STATUS_OFS = 8'h0c;    // read only state
   localparam logic [7:0] EDIT_SEL_OFS = 8'h10;  // preset and roi being edited
   localparam logic [7:0] BASE_EXP_OFS = 8'h14;  // ordinary exposure value
   localparam logic [7:0] PRE_EXP_OFS = 8'h18;   // exposure of edited preset
   localparam logic [7:0] PRE_OUT_OFS = 8'h1c;   // output pin and cause of edited preset
   localparam logic [7:0] ROI_GEOM_OFS = 8'h20;  // roi height and count
   localparam logic [7:0] PRE_ROI_OFS = 8'h24;   // roi vertical offset of edited preset
   // ----------------------------------------------------------------
   // ctrl field positions
   // ----------------------------------------------------------------
   localparam int CTRL_EN_BIT = 0;       // preset_seq_enable
   localparam int CTRL_SRC_LSB = 1;      // advance_event_select, 3 bits
   localparam int CTRL_RST_CMD_BIT = 4;  // write one: reset command
   localparam int CTRL_RST_SRC_BIT = 5;  // reset on acquisition end
   localparam int CTRL_MROI_BIT = 6;     // multiple roi mode
   localparam int CTRL_FEAT_EXP_BIT = 7; // per_preset_feature_on, exposure
   localparam int CTRL_FEAT_ROI_BIT = 8; // per_preset_feature_on, multiple roi
   // ----------------------------------------------------------------
   // reset values and limits
   // ----------------------------------------------------------------
   localparam logic [31:0] TOTAL_RST = 32'h0000_0001;
   localparam logic [31:0] REPEAT_RST = 32'h0000_0001;
   localparam logic [31:0] BASE_EXP_RST = 32'h0000_03e8;
   localparam logic [3:0] ROI_COUNT_MAX = 4'h8;
   localparam logic [3:0] ROI_COUNT_RST = 4'h1;
   localparam logic [11:0] ROI_HEIGHT_RST = 12'h040;
   // ----------------------------------------------------------------
   // increment sources and output causes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      frame_begin_event = 3'b000,
      accepted_frame_trigger_event = 3'b001,
      first_counter_done_event = 3'b010,
      input_pin_two = 3'b011,
      current_set_select_only = 3'b100
   } advance_src_t;
   typedef enum logic [1:0] {
      cause_off = 2'b00,
      exposure_begin_pulse = 2'b01
   } pulse_cause_t;
endpackage

// *** preset_sequencer.sv ***
// The register offsets and register access over Wishbone were decided locally.
`timescale 1ns/10ps
// Operation
// R1 - sequencing only while enable is active
// R2 - presets numbered from one, wrap after last
// R3 - advance after repeat count of events
// R4 - frame begin and trigger are synchronous
// R5 - counter, pin two, none are asynchronous
// R6 - reset source event returns to preset one
// R7 - synchronous class defers reset to next event
// R8 - asynchronous class resets at once
// R9 - per-preset feature overrides, ordinary copy read-only
// R10 - presets editable while another is in use
// R11 - per-preset output pin pulses on exposure
// R12 - roi geometry constant while cycling rois
// R13 - roi count at most eight
// R14 - multiple roi mode locked while feature active
// R15 - overlap moves following roi offset down
// R16 - event counter cleared on index change
module preset_sequencer #(
   parameter int NPRE = 16,
   parameter int NROI = 8,
   parameter int NLINE = 4,
   parameter int EXP_W = 24,
   parameter int OFS_W = 12
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RSTN,
   // wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // camera events, one-cycle pulses
   input wire logic FRAME_BEGIN,
   input wire logic FRAME_TRIG_OK,
   input wire logic COUNTER_DONE,
   input wire logic PIN_TWO,
   input wire logic EXPOSURE_BEGIN,
   input wire logic ACQ_END,
   // roi read port for the acquisition core
   input wire logic [2:0] ROI_RD_SEL,
   // outputs to the acquisition core
   output logic [EXP_W-1:0] EXPOSURE_TIME,
   output logic [3:0] ACTIVE_PRESET,
   output logic [OFS_W-1:0] ROI_OFFSET_Y,
   output logic MULTI_ROI_MODE,
   output logic [NLINE-1:0] PRESET_OUT_PULSE
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   localparam int IW = $clog2(NPRE);
   typedef struct packed {
      logic ack;                              // bus answer
      logic [31:0] rdata;                     // bus read data
      logic enable;                           // preset_seq_enable
      logic [2:0] src;                        // advance_event_select
      logic rst_on_acq_end;                   // reset source select
      logic mroi;                             // multiple roi mode
      logic feat_exp;                         // per-preset exposure on
      logic feat_roi;                         // per-preset roi on
      logic [IW:0] total;                     // preset_total
      logic [15:0] repeat_n;                  // events per preset
      logic [IW-1:0] idx;                     // zero-based active preset
      logic [15:0] cnt;                       // events seen in this preset
      logic pend;                             // deferred reset command or reset source event
      logic [IW-1:0] edit_p;                  // preset being edited
      logic [2:0] edit_r;                     // roi being edited
      logic [EXP_W-1:0] base_exp;             // ordinary exposure
      logic [NPRE-1:0][EXP_W-1:0] pexp;       // per-preset exposure
      logic [NPRE-1:0][1:0] ppin;             // preset_out_pin_pick
      logic [NPRE-1:0][1:0] pcause;           // preset_out_pulse_cause
      logic [OFS_W-1:0] roi_h;                // roi height
      logic [3:0] roi_n;                      // roi count
      logic [NPRE-1:0][NROI-1:0][OFS_W-1:0] pofs; // per-preset roi offsets
      logic [EXP_W-1:0] exp_out;              // exposure in effect
      logic [OFS_W-1:0] ofs_out;              // roi offset in effect
      logic [NLINE-1:0] pulse;                // output line pulses
      logic [3:0] act;                        // one-based active preset, registered
   } state_t;
   state_t s_reg, s_next;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // byte-lane merge of a write into the current word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return r;
   endfunction

   // synchronous class of increment source
   function automatic logic is_sync(input logic [2:0] src);
      return (src == preset_seq_pkg::frame_begin_event) ||
             (src == preset_seq_pkg::accepted_frame_trigger_event); // R4
   endfunction

   // ----------------------------------------------------------------
   // combinational next state
   // ----------------------------------------------------------------
   logic req;       // bus request in its first cycle
   logic wr;        // write taken this cycle
   logic evt;       // selected increment event
   logic rst_rq;    // reset command or reset source event
   logic cycling_roi; // roi geometry frozen
   logic [31:0] cur; // current value of addressed word
   logic [31:0] wv;  // merged write value
   logic [IW:0] nxt_idx; // one past active index
   logic [OFS_W:0] lim;  // bottom of edited roi

   always_comb begin
      s_next = s_reg;
      req = WB_CYC_I && WB_STB_I && !s_reg.ack;
      // a write lands at the edge where the master samples ack high
      wr = WB_CYC_I && WB_STB_I && WB_WE_I && s_reg.ack;
      cycling_roi = s_reg.enable && s_reg.feat_roi;
      nxt_idx = {1'b0, s_reg.idx} + 1'b1;
      lim = '0;
      // register read view, also the base for byte-lane merges
      cur = 32'h0000_0000;
      case (WB_ADR_I)
         preset_seq_pkg::CTRL_OFS: begin
            cur[preset_seq_pkg::CTRL_EN_BIT] = s_reg.enable;
            cur[preset_seq_pkg::CTRL_SRC_LSB +: 3] = s_reg.src;
            cur[preset_seq_pkg::CTRL_RST_SRC_BIT] = s_reg.rst_on_acq_end;
            cur[preset_seq_pkg::CTRL_MROI_BIT] = s_reg.mroi;
            cur[preset_seq_pkg::CTRL_FEAT_EXP_BIT] = s_reg.feat_exp;
            cur[preset_seq_pkg::CTRL_FEAT_ROI_BIT] = s_reg.feat_roi;
         end
         preset_seq_pkg::TOTAL_OFS: cur[IW:0] = s_reg.total;
         preset_seq_pkg::REPEAT_OFS: cur[15:0] = s_reg.repeat_n;
         preset_seq_pkg::STATUS_OFS: begin
            // one-based active preset, event count, deferred reset
            cur[IW:0] = nxt_idx;
            cur[23:8] = s_reg.cnt;
            cur[24] = s_reg.pend;
         end
         preset_seq_pkg::EDIT_SEL_OFS: begin
            cur[IW-1:0] = s_reg.edit_p;
            cur[10:8] = s_reg.edit_r;
         end
         preset_seq_pkg::BASE_EXP_OFS: cur[EXP_W-1:0] = s_reg.base_exp;
         preset_seq_pkg::PRE_EXP_OFS: cur[EXP_W-1:0] = s_reg.pexp[s_reg.edit_p];
         preset_seq_pkg::PRE_OUT_OFS: begin
            cur[1:0] = s_reg.ppin[s_reg.edit_p];
            cur[5:4] = s_reg.pcause[s_reg.edit_p];
         end
         preset_seq_pkg::ROI_GEOM_OFS: begin
            cur[OFS_W-1:0] = s_reg.roi_h;
            cur[19:16] = s_reg.roi_n;
         end
         preset_seq_pkg::PRE_ROI_OFS: cur[OFS_W-1:0] = s_reg.pofs[s_reg.edit_p][s_reg.edit_r];
         default: cur = 32'h0000_0000; // unmapped reads as zero, still acked
      endcase
      wv = merge(cur, WB_DAT_I, WB_SEL_I);

      // single-cycle answer: ack the cycle after the request, drop it after
      s_next.ack = req;
      s_next.rdata = req ? cur : s_reg.rdata;

      // register writes
      if (wr) begin
         case (WB_ADR_I)
            preset_seq_pkg::CTRL_OFS: begin
               s_next.enable = wv[preset_seq_pkg::CTRL_EN_BIT];
               s_next.src = wv[preset_seq_pkg::CTRL_SRC_LSB +: 3];
               s_next.rst_on_acq_end = wv[preset_seq_pkg::CTRL_RST_SRC_BIT];
               s_next.feat_exp = wv[preset_seq_pkg::CTRL_FEAT_EXP_BIT];
               s_next.feat_roi = wv[preset_seq_pkg::CTRL_FEAT_ROI_BIT];
               // mode is frozen until the roi feature is switched off
               if (!s_reg.feat_roi) begin
                  s_next.mroi = wv[preset_seq_pkg::CTRL_MROI_BIT]; // R14
               end
            end
            preset_seq_pkg::TOTAL_OFS: begin
               // zero or too many presets would leave the wrap undefined
               if (wv[15:0] == 16'h0000) begin
                  s_next.total = (IW+1)'(1);
               end else if (wv[15:0] > 16'(NPRE)) begin
                  s_next.total = (IW+1)'(NPRE);
               end else begin
                  s_next.total = wv[IW:0];
               end
            end
            preset_seq_pkg::REPEAT_OFS: s_next.repeat_n = wv[15:0];
            preset_seq_pkg::EDIT_SEL_OFS: begin
               s_next.edit_p = wv[IW-1:0];
               s_next.edit_r = wv[10:8];
            end
            preset_seq_pkg::BASE_EXP_OFS: begin
               // ordinary copy is read-only while the preset value rules
               if (!s_reg.feat_exp) begin
                  s_next.base_exp = wv[EXP_W-1:0]; // R9
               end
            end
            // any preset may be edited, also the one in use
            preset_seq_pkg::PRE_EXP_OFS: s_next.pexp[s_reg.edit_p] = wv[EXP_W-1:0]; // R10
            preset_seq_pkg::PRE_OUT_OFS: begin
               s_next.ppin[s_reg.edit_p] = wv[1:0]; // R11
               s_next.pcause[s_reg.edit_p] = wv[5:4];
            end
            preset_seq_pkg::ROI_GEOM_OFS: begin
               // geometry frozen while rois are cycled
               if (!cycling_roi) begin
                  s_next.roi_h = wv[OFS_W-1:0]; // R12
                  if (wv[19:16] > preset_seq_pkg::ROI_COUNT_MAX) begin
                     s_next.roi_n = preset_seq_pkg::ROI_COUNT_MAX; // R13
                  end else if (wv[19:16] == 4'h0) begin
                     s_next.roi_n = preset_seq_pkg::ROI_COUNT_RST;
                  end else begin
                     s_next.roi_n = wv[19:16];
                  end
               end
            end
            preset_seq_pkg::PRE_ROI_OFS: begin
               // only the vertical offset may differ per preset
               s_next.pofs[s_reg.edit_p][s_reg.edit_r] = wv[OFS_W-1:0]; // R12
               lim = {1'b0, wv[OFS_W-1:0]} + {1'b0, s_reg.roi_h};
               // push the next roi down when the edit would overlap it
               if ((4'({1'b0, s_reg.edit_r}) + 4'h1 < s_reg.roi_n) &&
                   (lim > {1'b0, s_reg.pofs[s_reg.edit_p][s_reg.edit_r + 3'h1]})) begin
                  s_next.pofs[s_reg.edit_p][s_reg.edit_r + 3'h1] = lim[OFS_W-1:0]; // R15
               end
            end
            default: s_next.enable = s_reg.enable; // unmapped write ignored
         endcase
      end

      // selected increment source; none leaves the index where it is
      case (s_reg.src)
         preset_seq_pkg::frame_begin_event: evt = FRAME_BEGIN; // R4
         preset_seq_pkg::accepted_frame_trigger_event: evt = FRAME_TRIG_OK; // R4
         preset_seq_pkg::first_counter_done_event: evt = COUNTER_DONE; // R5
         preset_seq_pkg::input_pin_two: evt = PIN_TWO; // R5
         default: evt = 1'b0; // R5
      endcase
      rst_rq = (wr && (WB_ADR_I == preset_seq_pkg::CTRL_OFS) && WB_SEL_I[0] &&
                WB_DAT_I[preset_seq_pkg::CTRL_RST_CMD_BIT]) ||
               (s_reg.rst_on_acq_end && ACQ_END); // R6

      // sequencing
      if (!s_reg.enable) begin
         s_next.idx = '0; // R1
         s_next.cnt = 16'h0000;
         s_next.pend = 1'b0;
      end else if (is_sync(s_reg.src)) begin
         if (evt) begin
            if (s_reg.pend || rst_rq) begin
               s_next.idx = '0; // R7
               s_next.cnt = 16'h0000; // R16
               s_next.pend = 1'b0;
            end else if (s_reg.cnt + 16'h0001 >= s_reg.repeat_n) begin
               s_next.cnt = 16'h0000; // R16
               s_next.idx = (nxt_idx >= s_reg.total) ? '0 : nxt_idx[IW-1:0]; // R2
            end else begin
               s_next.cnt = s_reg.cnt + 16'h0001; // R3
            end
         end else if (rst_rq) begin
            s_next.pend = 1'b1; // R7
         end
      end else begin
         s_next.pend = 1'b0;
         if (rst_rq) begin
            s_next.idx = '0; // R8
            s_next.cnt = 16'h0000; // R16
         end else if (evt) begin
            if (s_reg.cnt + 16'h0001 >= s_reg.repeat_n) begin
               s_next.cnt = 16'h0000; // R16
               s_next.idx = (nxt_idx >= s_reg.total) ? '0 : nxt_idx[IW-1:0]; // R2
            end else begin
               s_next.cnt = s_reg.cnt + 16'h0001; // R3
            end
         end
      end

      // values in effect, registered for the acquisition core
      s_next.exp_out = (s_reg.enable && s_reg.feat_exp) ? s_reg.pexp[s_reg.idx] :
                       s_reg.base_exp; // R9
      s_next.ofs_out = (cycling_roi && s_reg.mroi) ? s_reg.pofs[s_reg.idx][ROI_RD_SEL] :
                       s_reg.pofs[0][ROI_RD_SEL];
      s_next.pulse = '0;
      if (s_reg.enable && EXPOSURE_BEGIN &&
          (s_reg.pcause[s_reg.idx] == preset_seq_pkg::exposure_begin_pulse)) begin
         s_next.pulse[s_reg.ppin[s_reg.idx]] = 1'b1; // R11
      end
      s_next.act = 4'({1'b0, s_next.idx}) + 4'h1; // R2
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   // all state in one register; constants only under reset
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         s_reg <= '0;
         s_reg.total <= preset_seq_pkg::TOTAL_RST[IW:0];
         s_reg.repeat_n <= preset_seq_pkg::REPEAT_RST[15:0];
         s_reg.base_exp <= preset_seq_pkg::BASE_EXP_RST[EXP_W-1:0];
         s_reg.exp_out <= preset_seq_pkg::BASE_EXP_RST[EXP_W-1:0];
         s_reg.roi_n <= preset_seq_pkg::ROI_COUNT_RST;
         s_reg.roi_h <= preset_seq_pkg::ROI_HEIGHT_RST;
         s_reg.act <= 4'h1;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs straight from the state register
   assign WB_ACK_O = s_reg.ack;
   assign WB_DAT_O = s_reg.rdata;
   assign EXPOSURE_TIME = s_reg.exp_out;
   assign ACTIVE_PRESET = s_reg.act;
   assign ROI_OFFSET_Y = s_reg.ofs_out;
   assign MULTI_ROI_MODE = s_reg.mroi;
   assign PRESET_OUT_PULSE = s_reg.pulse;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_idle_index: assert property (@(posedge CLK) disable iff (!RSTN) // R1
      !s_reg.enable |=> s_reg.idx == '0)
      else $error("index not at first preset while idle");
   chk_index_wrap: assert property (@(posedge CLK) disable iff (!RSTN) // R2
      {1'b0, s_reg.idx} < s_reg.total)
      else $error("index beyond presets in use");
   chk_repeat_hold: assert property (@(posedge CLK) disable iff (!RSTN) // R3
      s_reg.enable && evt && !rst_rq && !s_reg.pend && !wr &&
      (s_reg.cnt + 16'h0001 < s_reg.repeat_n) |=> $stable(s_reg.idx))
      else $error("preset left before repeat count");
   chk_sync_defer: assert property (@(posedge CLK) disable iff (!RSTN) // R7
      s_reg.enable && is_sync(s_reg.src) && rst_rq && !evt && !wr
      |=> s_reg.pend ##0 $stable(s_reg.idx))
      else $error("synchronous reset not deferred");
   chk_async_reset: assert property (@(posedge CLK) disable iff (!RSTN) // R8
      s_reg.enable && !is_sync(s_reg.src) && rst_rq |=> s_reg.idx == '0 && s_reg.cnt == 16'h0000)
      else $error("asynchronous reset not immediate");
   chk_count_clear: assert property (@(posedge CLK) disable iff (!RSTN) // R16
      !$stable(s_reg.idx) |-> s_reg.cnt == 16'h0000)
      else $error("event count kept across index change");
   chk_exposure_pick: assert property (@(posedge CLK) disable iff (!RSTN) // R9
      s_reg.enable && s_reg.feat_exp |=> EXPOSURE_TIME == $past(s_reg.pexp[s_reg.idx]))
      else $error("exposure not taken from active preset");
   chk_roi_limit: assert property (@(posedge CLK) disable iff (!RSTN) // R13
      s_reg.roi_n <= preset_seq_pkg::ROI_COUNT_MAX && s_reg.roi_n != 4'h0)
      else $error("roi count out of range");
   chk_mroi_lock: assert property (@(posedge CLK) disable iff (!RSTN) // R14
      s_reg.feat_roi |=> $stable(s_reg.mroi))
      else $error("multiple roi mode changed while locked");
   chk_pulse_line: assert property (@(posedge CLK) disable iff (!RSTN) // R11
      s_reg.enable && EXPOSURE_BEGIN &&
      s_reg.pcause[s_reg.idx] == preset_seq_pkg::exposure_begin_pulse
      |=> PRESET_OUT_PULSE[$past(s_reg.ppin[s_reg.idx])] ##1
      (PRESET_OUT_PULSE == '0 || $past(EXPOSURE_BEGIN)))
      else $error("exposure pulse missing on preset line");
endmodule // preset_sequencer

// *** tb.sv ***
`timescale 1ns/10ps
module tb;
   // ----------------------------------------------------------------
   // stimulus, observation and bookkeeping
   // ----------------------------------------------------------------
   logic CLK, RSTN, WB_CYC_I, WB_STB_I, WB_WE_I; // clock, reset, bus controls
   logic [7:0] WB_ADR_I; // byte address
   logic [3:0] WB_SEL_I; // byte lanes
   logic [31:0] WB_DAT_I, WB_DAT_O; // bus data
   logic WB_ACK_O, MULTI_ROI_MODE; // slave answers
   logic [5:0] evt; // frame, trigger, counter, pin two, exposure, acq end
   logic [2:0] ROI_RD_SEL; // roi read select
   logic [23:0] EXPOSURE_TIME; // exposure in effect
   logic [3:0] ACTIVE_PRESET, PRESET_OUT_PULSE; // index and pin pulses
   logic [11:0] ROI_OFFSET_Y; // selected roi offset
   logic [31:0] qv[$], qm[$]; // expected read data and compare mask
   logic [23:0] e[3]; // random exposure per preset
   int n_mismatch = 0, num_checks = 0;
   localparam logic [31:0] en = 32'h1 << preset_seq_pkg::CTRL_EN_BIT;
   localparam logic [31:0] rcmd = 32'h1 << preset_seq_pkg::CTRL_RST_CMD_BIT;
   localparam logic [31:0] racq = 32'h1 << preset_seq_pkg::CTRL_RST_SRC_BIT;
   localparam logic [31:0] mroi = 32'h1 << preset_seq_pkg::CTRL_MROI_BIT;
   localparam logic [31:0] fexp = 32'h1 << preset_seq_pkg::CTRL_FEAT_EXP_BIT;
   localparam logic [31:0] froi = 32'h1 << preset_seq_pkg::CTRL_FEAT_ROI_BIT;
   localparam logic [7:0] st = preset_seq_pkg::STATUS_OFS;
   preset_sequencer dut (.CLK(CLK), .RSTN(RSTN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
      .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
      .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .FRAME_BEGIN(evt[0]), .FRAME_TRIG_OK(evt[1]),
      .COUNTER_DONE(evt[2]), .PIN_TWO(evt[3]), .EXPOSURE_BEGIN(evt[4]), .ACQ_END(evt[5]),
      .ROI_RD_SEL(ROI_RD_SEL), .EXPOSURE_TIME(EXPOSURE_TIME), .ACTIVE_PRESET(ACTIVE_PRESET),
      .ROI_OFFSET_Y(ROI_OFFSET_Y), .MULTI_ROI_MODE(MULTI_ROI_MODE),
      .PRESET_OUT_PULSE(PRESET_OUT_PULSE));
   // 25 ns clock
   initial begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   // verdict in one place, also reached from a bus timeout
   task summarize();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // direct port comparison, sampled at the falling edge where values are settled
   task chk(input string n, input logic [31:0] x, input logic [31:0] g);
      num_checks++;
      if (g !== x) begin
         n_mismatch++;
         $display("MISMATCH %s exp %h got %h", n, x, g);
      end
   endtask
   // one classic cycle; a read notes its expected data for the monitor
   task wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
      int k;
      if (!we) begin
         qv.push_back(d);
         qm.push_back(m);
      end
      @(posedge CLK);
      {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I} <= {1'b1, 1'b1, we, a};
      WB_DAT_I <= we ? d : 32'h0;
      k = 0;
      do begin
         @(posedge CLK);
         k++;
      end while (WB_ACK_O !== 1'b1 && k < 20);
      if (k >= 20) begin
         n_mismatch++;
         $display("MISMATCH ack exp 1 got timeout");
         summarize();
      end else begin
         {WB_CYC_I, WB_STB_I} <= 2'b00;
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d, 32'h0);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
      wb(1'b0, a, x & m, m);
   endtask
   // one-cycle event pulse, then room for index and exposure to settle
   task pulse(input int i);
      @(posedge CLK);
      evt[i] <= 1'b1;
      @(posedge CLK);
      evt <= 6'h00;
      @(posedge CLK);
      @(negedge CLK);
   endtask
   // read monitor: oldest note against each read acknowledge
   always @(posedge CLK) begin
      if (RSTN && WB_ACK_O === 1'b1 && !WB_WE_I) begin
         num_checks++;
         if (qv.size() == 0 || (WB_DAT_O & qm[0]) !== qv[0]) begin
            n_mismatch++;
            $display("MISMATCH rdata %h exp %h got %h", WB_ADR_I, qv[0], WB_DAT_O & qm[0]);
         end
         if (qv.size() != 0) void'(qv.pop_front());
         if (qm.size() != 0) void'(qm.pop_front());
      end
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(78));
      {RSTN, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I, evt} = '0;
      WB_SEL_I = 4'hf;
      ROI_RD_SEL = 3'($urandom);
      repeat (10) @(posedge CLK);
      RSTN <= 1'b1;
      @(negedge CLK);
      chk("preset", 32'h1, 32'(ACTIVE_PRESET));
      rd(preset_seq_pkg::TOTAL_OFS, 32'h1, 32'h1f);
      rd(preset_seq_pkg::BASE_EXP_OFS, 32'h3e8, 32'hff_ffff);
      rd(8'h30, 32'h0, 32'hffff_ffff);
      pulse(0);
      rd(st, 32'h1, 32'h1f);
      // three presets, two events each, random exposures
      wr(preset_seq_pkg::TOTAL_OFS, 32'h3);
      wr(preset_seq_pkg::REPEAT_OFS, 32'h2);
      for (int p = 0; p < 3; p++) begin
         e[p] = 24'($urandom);
         wr(preset_seq_pkg::EDIT_SEL_OFS, 32'(p));
         wr(preset_seq_pkg::PRE_EXP_OFS, 32'(e[p]));
      end
      wr(preset_seq_pkg::CTRL_OFS, en | fexp);
      wr(preset_seq_pkg::BASE_EXP_OFS, 32'h5);
      rd(preset_seq_pkg::BASE_EXP_OFS, 32'h3e8, 32'hff_ffff);
      for (int k = 0; k < 8; k++) begin
         pulse(0);
         chk("exposure", 32'(e[((k + 1) / 2) % 3]), 32'(EXPOSURE_TIME));
         rd(st, 32'(((k + 1) % 2) << 8) | 32'(((k + 1) / 2) % 3 + 1), 32'hff_ff1f);
      end
      wr(preset_seq_pkg::CTRL_OFS, en | fexp | rcmd);
      rd(st, 32'h0100_0002, 32'h0100_001f);
      pulse(0);
      rd(st, 32'h1, 32'h01ff_ff1f);
      // each increment source, its class and the reset timing
      wr(preset_seq_pkg::REPEAT_OFS, 32'h1);
      for (int s = 0; s < 5; s++) begin
         wr(preset_seq_pkg::CTRL_OFS, 32'h0);
         wr(preset_seq_pkg::CTRL_OFS, en | 32'(s << 1));
         pulse((s + 1) % 4);
         rd(st, 32'h1, 32'h1f);
         pulse(s % 4);
         rd(st, (s < 4) ? 32'h2 : 32'h1, 32'h1f);
         wr(preset_seq_pkg::CTRL_OFS, en | 32'(s << 1) | rcmd);
         rd(st, (s < 2) ? 32'h0100_0002 : 32'h1, 32'h0100_001f);
      end
      wr(preset_seq_pkg::CTRL_OFS, en | racq | 32'h4);
      pulse(2);
      pulse(5);
      rd(st, 32'h1, 32'h1f);
      // exposure pulse on the active preset's pin, one cycle only
      wr(preset_seq_pkg::EDIT_SEL_OFS, 32'h0);
      wr(preset_seq_pkg::PRE_OUT_OFS, 32'h12);
      @(posedge CLK);
      evt[4] <= 1'b1;
      @(posedge CLK);
      evt <= 6'h00;
      @(negedge CLK);
      chk("pulse", 32'h4, 32'(PRESET_OUT_PULSE));
      @(negedge CLK);
      chk("pulse", 32'h0, 32'(PRESET_OUT_PULSE));
      // roi count clamp, overlap repair, geometry and mode locks
      wr(preset_seq_pkg::CTRL_OFS, 32'h0);
      wr(preset_seq_pkg::ROI_GEOM_OFS, 32'h000f_0040);
      rd(preset_seq_pkg::ROI_GEOM_OFS, 32'h0008_0040, 32'h000f_0fff);
      wr(preset_seq_pkg::EDIT_SEL_OFS, 32'h100);
      wr(preset_seq_pkg::PRE_ROI_OFS, 32'h50);
      wr(preset_seq_pkg::EDIT_SEL_OFS, 32'h0);
      wr(preset_seq_pkg::PRE_ROI_OFS, 32'h30);
      wr(preset_seq_pkg::EDIT_SEL_OFS, 32'h100);
      rd(preset_seq_pkg::PRE_ROI_OFS, 32'h70, 32'hfff);
      wr(preset_seq_pkg::CTRL_OFS, mroi);
      wr(preset_seq_pkg::CTRL_OFS, en | mroi | froi);
      wr(preset_seq_pkg::ROI_GEOM_OFS, 32'h0002_0020);
      rd(preset_seq_pkg::ROI_GEOM_OFS, 32'h0008_0040, 32'h000f_0fff);
      wr(preset_seq_pkg::CTRL_OFS, en | froi);
      rd(preset_seq_pkg::CTRL_OFS, mroi, mroi);
      @(negedge CLK);
      chk("mode", 32'h1, 32'(MULTI_ROI_MODE));
      // preset 0 rois: 0x30, 0x70 after the overlap push, 0x90 pushed by the first edit
      chk("roi offset", (ROI_RD_SEL == 3'h0) ? 32'h30 : (ROI_RD_SEL == 3'h1) ? 32'h70 :
          (ROI_RD_SEL == 3'h2) ? 32'h90 : 32'h0, 32'(ROI_OFFSET_Y));
      repeat (4) @(posedge CLK);
      summarize();
   end
endmodule // tb
